// ### src/scan_motor_pkg.sv
// Constants shared by the scan stepper configuration block and its sequencer.
// Assumes an 8-bit register address space with byte-wide registers.
package scan_motor_pkg;
  localparam logic [7:0] LINE_SKIP_COUNT_OFS = 8'h44;
  localparam logic [7:0] MOTOR_DRIVE_CONFIG_OFS = 8'h45;
  localparam logic [7:0] SCAN_STEP_PERIOD_HIGH_OFS = 8'h46;
  localparam logic [7:0] SCAN_STEP_PERIOD_LOW_OFS = 8'h47;

  localparam logic [7:0] LINE_SKIP_COUNT_RST = 8'h00;
  localparam logic [7:0] MOTOR_DRIVE_CONFIG_RST = 8'h00;
  localparam logic [7:0] SCAN_STEP_PERIOD_HIGH_RST = 8'h00;
  localparam logic [7:0] SCAN_STEP_PERIOD_LOW_RST = 8'h02;

  localparam int CFG_MICROSTEP_BIT = 0;
  localparam int CFG_DUAL_SENSE_BIT = 1;
  localparam int CFG_POL_A_BIT = 2;
  localparam int CFG_POL_B_BIT = 3;
  localparam int CFG_DRIVE_EN_BIT = 4;
  localparam int CFG_SKIP_PHASE_BIT = 5;

  localparam logic [8:0] LINES_PER_GROUP = 9'h100;
  localparam logic [15:0] MIN_STEP_PERIOD = 16'h0002;
  localparam int MICROSTEPS_PER_FULL = 8;

  // Winding order in a nibble: {A, B, A_n, B_n}
  typedef enum logic [1:0] {
    PH_AB = 2'b00,
    PH_BAN = 2'b01,
    PH_ANBN = 2'b11,
    PH_BNA = 2'b10
  } step_phase_t;
endpackage

// ### src/step_sequencer.sv
// Two-phase full-step sequencer driving the four winding outputs.
// Assumes advance is a one-cycle pulse on sys_clk.
`timescale 1ns/1ns
`default_nettype none
module step_sequencer (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic advance,
  input wire logic polA,
  input wire logic polB,
  input wire logic driveEnable,
  output logic [3:0] winding,
  output logic [3:0] windingOe
);
  typedef struct packed {
    scan_motor_pkg::step_phase_t phase;
    logic [3:0] winding;
    logic [3:0] windingOe;
  } seq_state_t;

  seq_state_t state_reg;
  seq_state_t state_next;

  function automatic logic [3:0] energized(input scan_motor_pkg::step_phase_t ph);
    case (ph)
      scan_motor_pkg::PH_AB: energized = 4'hC;
      scan_motor_pkg::PH_BAN: energized = 4'h6;
      scan_motor_pkg::PH_ANBN: energized = 4'h3;
      default: energized = 4'h9;
    endcase
  endfunction

  always_comb begin
    state_next = state_reg;
    if (advance) begin
      case (state_reg.phase)
        scan_motor_pkg::PH_AB: state_next.phase = scan_motor_pkg::PH_BAN;
        scan_motor_pkg::PH_BAN: state_next.phase = scan_motor_pkg::PH_ANBN;
        scan_motor_pkg::PH_ANBN: state_next.phase = scan_motor_pkg::PH_BNA;
        default: state_next.phase = scan_motor_pkg::PH_AB;
      endcase
    end
    // Polarity inverts the A pair and the B pair independently
    state_next.winding = energized(state_next.phase) ^ {polA, polB, polA, polB};
    state_next.windingOe = {4{driveEnable}};
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= '{phase: scan_motor_pkg::PH_AB, winding: 4'hC, windingOe: 4'h0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign winding = state_reg.winding;
  assign windingOe = state_reg.windingOe;

  polarity_applied_a: assert property (@(posedge sys_clk) disable iff (reset)
    1'b1 |=> winding == (energized(state_reg.phase) ^ {polA, polB, polA, polB})
    || $changed(polA) || $changed(polB))
    else $error("Winding polarity does not match phase and polarity inputs");
  phase_advance_a: assert property (@(posedge sys_clk) disable iff (reset)
    advance |=> state_reg.phase != $past(state_reg.phase))
    else $error("Step phase did not advance on a step");
  phase_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    !advance |=> $stable(state_reg.phase))
    else $error("Step phase moved without a step");
  tristate_a: assert property (@(posedge sys_clk) disable iff (reset)
    !driveEnable |=> windingOe == 4'h0)
    else $error("Winding outputs driven while disabled");
  cover_full_cycle: cover property (@(posedge sys_clk) disable iff (reset)
    state_reg.phase == scan_motor_pkg::PH_BNA && advance);
endmodule
`default_nettype wire

// ### src/scan_stepper_motor_config.sv
// Stepper configuration registers, scan microstep timebase and n-of-m line saving.
// Assumes register strobes, pixelTick, lineDone and groupStart are sys_clk pulses.
//
// Notes on behaviour
// - A nonzero line-skip value t keeps 256 minus t lines out of every group of m lines.
// - A line-skip value of zero keeps every line.
// - Config bit 0 chooses full steps (0) or microsteps (1).
// - Config bit 1 chooses one or two sensing phases, and microstepping needs two.
// - Config bits 2 and 3 invert the active level of the A pair and the B pair.
// - Config bit 4 releases all four winding outputs (0) or drives them (1).
// - Config bit 5 only drives the skipPhaseBlueFirst output (whether red or blue precedes green); the line saving here ignores it.
// - While scanning, one microstep is issued per programmed 16-bit pixel-period count.
`timescale 1ns/1ns
`default_nettype none
module scan_stepper_motor_config #(
  parameter int MICROSTEPS = scan_motor_pkg::MICROSTEPS_PER_FULL
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  output logic regRdValid,
  input wire logic scanning,
  input wire logic pixelTick,
  input wire logic groupStart,
  input wire logic lineDone,
  output logic lineSave,
  output logic skipPhaseBlueFirst,
  output logic dualPhaseSense,
  output logic microStep,
  output logic [3:0] winding,
  output logic [3:0] windingOe
);
  typedef struct packed {
    logic [7:0] lineSkipCount;
    logic [7:0] motorDriveConfig;
    logic [7:0] periodHigh;
    logic [7:0] periodLow;
    logic [7:0] rdData;
    logic rdValid;
    logic [15:0] pixCount;
    logic microStep;
    logic fullStep;
    logic [$clog2(MICROSTEPS)-1:0] microIndex;
    logic [8:0] keptCount;
    logic lineSave;
  } cfg_state_t;

  cfg_state_t state_reg;
  cfg_state_t state_next;
  logic microMode;
  logic [15:0] stepPeriod;
  logic [8:0] keepLimit;

  function automatic logic [7:0] readMux(input cfg_state_t s, input logic [7:0] addr);
    case (addr)
      scan_motor_pkg::LINE_SKIP_COUNT_OFS: readMux = s.lineSkipCount;
      scan_motor_pkg::MOTOR_DRIVE_CONFIG_OFS: readMux = s.motorDriveConfig;
      scan_motor_pkg::SCAN_STEP_PERIOD_HIGH_OFS: readMux = s.periodHigh;
      scan_motor_pkg::SCAN_STEP_PERIOD_LOW_OFS: readMux = s.periodLow;
      default: readMux = 8'h00;
    endcase
  endfunction

  // Microstepping only takes effect with both sensing phases present
  assign microMode = state_reg.motorDriveConfig[scan_motor_pkg::CFG_MICROSTEP_BIT]
    & state_reg.motorDriveConfig[scan_motor_pkg::CFG_DUAL_SENSE_BIT];
  assign stepPeriod = {state_reg.periodHigh, state_reg.periodLow};
  assign keepLimit = scan_motor_pkg::LINES_PER_GROUP - {1'b0, state_reg.lineSkipCount};

  always_comb begin
    state_next = state_reg;
    state_next.rdValid = regRead;
    state_next.microStep = 1'b0;
    state_next.fullStep = 1'b0;
    state_next.lineSave = 1'b0;
    if (regRead) begin
      state_next.rdData = readMux(state_reg, regAddr);
    end
    if (regWrite) begin
      case (regAddr)
        scan_motor_pkg::LINE_SKIP_COUNT_OFS: state_next.lineSkipCount = regWrData;
        scan_motor_pkg::MOTOR_DRIVE_CONFIG_OFS: state_next.motorDriveConfig = regWrData;
        scan_motor_pkg::SCAN_STEP_PERIOD_HIGH_OFS: state_next.periodHigh = regWrData;
        scan_motor_pkg::SCAN_STEP_PERIOD_LOW_OFS: state_next.periodLow = regWrData;
        default: ;
      endcase
    end
    // A period below two is outside what software may program, so no guard here
    if (!scanning) begin
      state_next.pixCount = 16'h0000;
    end else if (pixelTick) begin
      if (state_reg.pixCount + 16'h0001 >= stepPeriod) begin
        state_next.pixCount = 16'h0000;
        state_next.microStep = 1'b1;
        if (!microMode || state_reg.microIndex == ($clog2(MICROSTEPS))'(MICROSTEPS - 1)) begin
          state_next.microIndex = '0;
          state_next.fullStep = 1'b1;
        end else begin
          state_next.microIndex = state_reg.microIndex + 1'b1;
        end
      end else begin
        state_next.pixCount = state_reg.pixCount + 16'h0001;
      end
    end
    if (groupStart) begin
      state_next.keptCount = 9'h000;
    end
    if (lineDone) begin
      if (state_reg.lineSkipCount == 8'h00) begin
        state_next.lineSave = 1'b1;
      end else if (!groupStart && state_reg.keptCount < keepLimit) begin
        state_next.lineSave = 1'b1;
        state_next.keptCount = state_reg.keptCount + 9'h001;
      end else if (groupStart) begin
        state_next.lineSave = 1'b1;
        state_next.keptCount = 9'h001;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.lineSkipCount <= scan_motor_pkg::LINE_SKIP_COUNT_RST;
      state_reg.motorDriveConfig <= scan_motor_pkg::MOTOR_DRIVE_CONFIG_RST;
      state_reg.periodHigh <= scan_motor_pkg::SCAN_STEP_PERIOD_HIGH_RST;
      state_reg.periodLow <= scan_motor_pkg::SCAN_STEP_PERIOD_LOW_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  step_sequencer u_seq (
    .sys_clk(sys_clk),
    .reset(reset),
    .advance(state_reg.fullStep),
    .polA(state_reg.motorDriveConfig[scan_motor_pkg::CFG_POL_A_BIT]),
    .polB(state_reg.motorDriveConfig[scan_motor_pkg::CFG_POL_B_BIT]),
    .driveEnable(state_reg.motorDriveConfig[scan_motor_pkg::CFG_DRIVE_EN_BIT]),
    .winding(winding),
    .windingOe(windingOe)
  );

  assign regRdData = state_reg.rdData;
  assign regRdValid = state_reg.rdValid;
  assign lineSave = state_reg.lineSave;
  assign skipPhaseBlueFirst = state_reg.motorDriveConfig[scan_motor_pkg::CFG_SKIP_PHASE_BIT];
  assign dualPhaseSense = state_reg.motorDriveConfig[scan_motor_pkg::CFG_DUAL_SENSE_BIT];
  assign microStep = state_reg.microStep;

  keep_all_a: assert property (@(posedge sys_clk) disable iff (reset)
    lineDone && state_reg.lineSkipCount == 8'h00 |=> lineSave)
    else $error("Line dropped while line skipping is bypassed");
  keep_limit_a: assert property (@(posedge sys_clk) disable iff (reset)
    state_reg.lineSkipCount != 8'h00 && !groupStart |-> state_reg.keptCount <= keepLimit)
    else $error("More lines kept than 256 minus t in a group");
  keep_quota_a: assert property (@(posedge sys_clk) disable iff (reset)
    lineDone && !groupStart && state_reg.lineSkipCount != 8'h00
    && state_reg.keptCount < keepLimit |=> lineSave)
    else $error("Line dropped before the group quota was reached");
  step_spacing_a: assert property (@(posedge sys_clk) disable iff (reset)
    scanning && pixelTick && stepPeriod >= scan_motor_pkg::MIN_STEP_PERIOD
    && state_reg.pixCount + 16'h0001 == stepPeriod |=> microStep)
    else $error("Microstep missing at the programmed period");
  no_idle_step_a: assert property (@(posedge sys_clk) disable iff (reset)
    !scanning |=> !microStep)
    else $error("Microstep issued while not scanning");
  full_mode_a: assert property (@(posedge sys_clk) disable iff (reset)
    !microMode && microStep |=> winding != $past(winding))
    else $error("Full-step mode issued a step without a phase change");
  read_back_a: assert property (@(posedge sys_clk) disable iff (reset)
    regRead && !regWrite && regAddr == scan_motor_pkg::MOTOR_DRIVE_CONFIG_OFS
    |=> regRdValid && regRdData == $past(state_reg.motorDriveConfig))
    else $error("Motor configuration read back wrong");
  // Register writes must reach the logic they steer on the very next edge
  period_high_a: assert property (@(posedge sys_clk) disable iff (reset)
    regWrite && regAddr == scan_motor_pkg::SCAN_STEP_PERIOD_HIGH_OFS
    |=> stepPeriod[15:8] == $past(regWrData))
    else $error("Step period high byte not stored");
  period_low_a: assert property (@(posedge sys_clk) disable iff (reset)
    regWrite && regAddr == scan_motor_pkg::SCAN_STEP_PERIOD_LOW_OFS
    |=> stepPeriod[7:0] == $past(regWrData))
    else $error("Step period low byte not stored");
  blue_first_a: assert property (@(posedge sys_clk) disable iff (reset)
    regWrite && regAddr == scan_motor_pkg::MOTOR_DRIVE_CONFIG_OFS
    |=> skipPhaseBlueFirst == $past(regWrData[scan_motor_pkg::CFG_SKIP_PHASE_BIT]))
    else $error("Colour order output does not follow the configuration");
  sense_phase_a: assert property (@(posedge sys_clk) disable iff (reset)
    regWrite && regAddr == scan_motor_pkg::MOTOR_DRIVE_CONFIG_OFS
    |=> dualPhaseSense == $past(regWrData[scan_motor_pkg::CFG_DUAL_SENSE_BIT]))
    else $error("Sensing phase output does not follow the configuration");
  // The sequencer registers its enable once more, so the pins follow two edges later
  drive_enable_a: assert property (@(posedge sys_clk) disable iff (reset)
    regWrite && regAddr == scan_motor_pkg::MOTOR_DRIVE_CONFIG_OFS
    |=> ##1 windingOe == {4{$past(regWrData[scan_motor_pkg::CFG_DRIVE_EN_BIT], 2)}})
    else $error("Winding output enable does not follow the configuration");
  // A configuration write one cycle earlier may legally move the windings
  micro_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    microMode && microStep && state_reg.microIndex != '0 && !$past(regWrite)
    |=> $stable(winding))
    else $error("Windings moved on an intermediate microstep");
  line_drop_a: assert property (@(posedge sys_clk) disable iff (reset)
    lineDone && !groupStart && state_reg.lineSkipCount != 8'h00
    && state_reg.keptCount >= keepLimit |=> !lineSave)
    else $error("Line kept after the group quota was used up");
  step_gap_a: assert property (@(posedge sys_clk) disable iff (reset)
    microStep && stepPeriod >= scan_motor_pkg::MIN_STEP_PERIOD |=> !microStep)
    else $error("Two microsteps in a row at a legal period");
  pix_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
    !scanning |=> state_reg.pixCount == 16'h0000)
    else $error("Pixel-period count kept running while not scanning");
  cover_skip: cover property (@(posedge sys_clk) disable iff (reset)
    lineDone && state_reg.lineSkipCount != 8'h00 ##1 !lineSave);
  cover_micro: cover property (@(posedge sys_clk) disable iff (reset)
    microMode && microStep && !state_reg.fullStep);
  cover_drive: cover property (@(posedge sys_clk) disable iff (reset) windingOe == 4'hF);
  cover_group_restart: cover property (@(posedge sys_clk) disable iff (reset)
    lineDone && groupStart && state_reg.lineSkipCount != 8'h00);
endmodule
`default_nettype wire

// ### tb/motor_windings_model.sv
// Behavioural stand-in for the power transistors and the four windings.
// Assumes the polarity inputs mirror what the host last put in config bits 2 and 3.
`timescale 1ns/1ns
`default_nettype none
module motor_windings_model (
  input wire logic [3:0] winding,
  input wire logic [3:0] windingOe,
  input wire logic polA,
  input wire logic polB,
  output logic [3:0] energized
);
  // A released pin drives no transistor, so its winding stays dark
  assign energized = windingOe & (winding ^ {polA, polB, polA, polB});
endmodule
`default_nettype wire

// ### tb/test_scan_stepper_motor_config.sv
// Self-checking bench for the scan stepper configuration block.
// Assumes a 50 MHz sys_clk and the register strobe protocol of the block.
`timescale 1ns/1ns
`default_nettype none
module test_scan_stepper_motor_config;
  logic sys_clk, reset, regWrite, regRead, scanning, pixelTick, groupStart, lineDone;
  logic [7:0] regAddr, regWrData, regRdData;
  logic regRdValid, lineSave, skipPhaseBlueFirst, dualPhaseSense, microStep, polA, polB;
  logic [3:0] winding, windingOe, energized;
  logic [3:0] seqTab [4];
  int errors, samples_checked, steps, n, stepBase;
  scan_stepper_motor_config #(.MICROSTEPS(8)) dut (.sys_clk(sys_clk), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .regRdValid(regRdValid), .scanning(scanning),
    .pixelTick(pixelTick), .groupStart(groupStart), .lineDone(lineDone),
    .lineSave(lineSave), .skipPhaseBlueFirst(skipPhaseBlueFirst),
    .dualPhaseSense(dualPhaseSense), .microStep(microStep), .winding(winding),
    .windingOe(windingOe));
  motor_windings_model motor (.winding(winding), .windingOe(windingOe), .polA(polA),
    .polB(polB), .energized(energized));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      steps <= 0;
    end else if (microStep === 1'b1) begin
      steps <= steps + 1;
    end
  end
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 chk({7'h00, regRdValid}, 8'h01);
    chk(regRdData, exp);
  endtask
  task automatic line(input logic gs, input logic exp);
    @(posedge sys_clk);
    lineDone <= 1'b1;
    groupStart <= gs;
    @(posedge sys_clk);
    lineDone <= 1'b0;
    groupStart <= 1'b0;
    #1 chk({7'h00, lineSave}, {7'h00, exp});
  endtask
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge sys_clk);
      pixelTick <= 1'b1;
      @(posedge sys_clk);
      pixelTick <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
    #1;
  endtask
  initial begin
    {regWrite, regRead, scanning, pixelTick, groupStart, lineDone, polA, polB} = 8'h00;
    regAddr = 8'h00;
    regWrData = 8'h00;
    errors = 0;
    samples_checked = 0;
    seqTab = '{4'hC, 4'h6, 4'h3, 4'h9};
    reset = 1'b1;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    rd(8'h44, scan_motor_pkg::LINE_SKIP_COUNT_RST);
    rd(8'h45, scan_motor_pkg::MOTOR_DRIVE_CONFIG_RST);
    rd(8'h46, scan_motor_pkg::SCAN_STEP_PERIOD_HIGH_RST);
    rd(8'h47, scan_motor_pkg::SCAN_STEP_PERIOD_LOW_RST);
    wr(8'h48, 8'h5A);
    rd(8'h48, 8'h00);
    wr(8'h46, 8'hA5);
    rd(8'h46, 8'hA5);
    wr(8'h45, 8'h22);
    rd(8'h45, 8'h22);
    #1 chk({6'h00, dualPhaseSense, skipPhaseBlueFirst}, 8'h03);
    chk({4'h0, windingOe}, 8'h00);
    wr(8'h44, 8'h00);
    line(1'b1, 1'b1);
    repeat (3) line(1'b0, 1'b1);
    wr(8'h44, 8'hFE);
    line(1'b1, 1'b1);
    line(1'b0, 1'b1);
    line(1'b0, 1'b0);
    line(1'b1, 1'b1);
    // The period stays at two pixel periods or more, as the host must keep it
    wr(8'h46, 8'h00);
    wr(8'h47, 8'h03);
    polA <= 1'b1;
    wr(8'h45, 8'h14);
    repeat (2) @(posedge sys_clk);
    #1 chk({4'h0, windingOe}, 8'h0F);
    chk({4'h0, energized}, 8'h0C);
    chk({6'h00, dualPhaseSense, skipPhaseBlueFirst}, 8'h00);
    scanning <= 1'b1;
    stepBase = steps;
    for (n = 1; n <= 4; n++) begin
      ticks(3);
      chk(8'(steps - stepBase), 8'(n));
      chk({4'h0, energized}, {4'h0, seqTab[n % 4]});
    end
    scanning <= 1'b0;
    wr(8'h47, 8'h02);
    polA <= 1'b0;
    wr(8'h45, 8'h13);
    scanning <= 1'b1;
    ticks(14);
    chk({4'h0, energized}, 8'h0C);
    ticks(2);
    chk({4'h0, energized}, 8'h06);
    wr(8'h45, 8'h11);
    ticks(2);
    chk({4'h0, energized}, 8'h03);
    report_and_stop();
  end
endmodule
`default_nettype wire
